/* src/pwm_timer_reset_and_raw_irq.sv */
// Purpose: soft reset control and raw interrupt status of three pwm channels
// Assumes: register port is a single-cycle strobe from the command decoder
// Notes: script memory lives outside; this block only steers its pointer
// How it works
// RULE1: write-only reset register, upper bits ignored
// RULE2: bits 2..0 each reset one channel
// RULE3: reset bit acts once, no release
// RULE4: reset rewinds pointer, loads, stays stopped
// RULE5: reset halts channel engine and timer
// RULE6: script contents never touched by reset
// RULE7: reset leaves pending flags untouched
// RULE8: read-only raw status, bits 7:6 zero
// RULE9: cycle completion raises cycle flag
// RULE10: script completion raises script flag
// RULE11: script flags bits 5..3, reset zero
// RULE12: cycle flags bits 2..0, reset zero
// RULE13: raw bit shows pending regardless of mask
// RULE14: cycle mask, one masks, resets zero
// RULE15: masked status is raw gated by masks
// RULE16: several reset bits act together
`timescale 1ns/1ps
module pwm_timer_reset_and_raw_irq (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // channel events from pwm engines
  input wire logic [pwm_reset_pkg::NUM_CH-1:0] cycle_done_evt,
  input wire logic [pwm_reset_pkg::NUM_CH-1:0] script_done_evt,
  input wire logic [pwm_reset_pkg::NUM_CH-1:0] engine_start,
  // mask bits from the channel config registers
  input wire logic [pwm_reset_pkg::NUM_CH-1:0] cycle_done_mask,
  input wire logic [pwm_reset_pkg::NUM_CH-1:0] script_done_mask,
  // channel control toward engines, then masked status and interrupt summary
  output logic [pwm_reset_pkg::NUM_CH-1:0] channel_reset_pulse,
  output logic [pwm_reset_pkg::NUM_CH-1:0] channel_running,
  output logic [pwm_reset_pkg::NUM_CH-1:0] script_ptr_rewind,
  output logic [pwm_reset_pkg::NUM_CH-1:0] pattern_load,
  output logic [5:0] masked_status,
  output logic irq_any
);
  import pwm_reset_pkg::*;

  // ==================================================================
  // state
  typedef struct packed {
    logic [NUM_CH-1:0] rst_pulse;   // one-cycle channel reset
    ch_state_e [NUM_CH-1:0] ch;     // per channel engine state
    logic [NUM_CH-1:0] cyc_flag;    // raw cycle done flags
    logic [NUM_CH-1:0] scr_flag;    // raw script done flags
    logic [7:0] rdata;              // registered read data
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [NUM_CH-1:0] rst_sel;       // channels picked by this write
  logic [NUM_CH-1:0] clr_cyc;       // cycle flag clear request
  logic [NUM_CH-1:0] clr_scr;       // script flag clear request
  logic [5:0] raw_status;           // raw status word

  // ==================================================================
  // helpers
  // one strobe aimed at one register address
  function automatic logic addr_hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  // next state
  always_comb begin
    st_d = st_q;
    // RULE1: decode write-only register
    // RULE16: all selected bits at once
    // a zero bit selects nothing, so other channels keep running
    rst_sel = '0;
    if (addr_hit(reg_wr, reg_addr, SOFT_RESET_ADDR)) begin
      rst_sel = reg_wdata[RESET_CH_LSB +: NUM_CH];
    end
    // clear register write, one clears a flag
    clr_cyc = '0;
    clr_scr = '0;
    if (addr_hit(reg_wr, reg_addr, IRQ_CLEAR_ADDR)) begin
      clr_cyc = reg_wdata[CYCLE_FLAG_LSB +: NUM_CH];
      clr_scr = reg_wdata[SCRIPT_FLAG_LSB +: NUM_CH];
    end
    // RULE3: pulse only, self clearing
    st_d.rst_pulse = rst_sel;
    for (int i = 0; i < NUM_CH; i++) begin
      // RULE5: halt channel engine on reset
      if (rst_sel[i]) begin
        st_d.ch[i] = CH_LOADING;
      end else begin
        case (st_q.ch[i])
          // RULE4: load first pattern then stop
          CH_LOADING: st_d.ch[i] = CH_STOPPED;
          CH_STOPPED: begin
            if (engine_start[i]) begin
              st_d.ch[i] = CH_RUNNING;
            end
          end
          CH_RUNNING: st_d.ch[i] = CH_RUNNING;
          default: st_d.ch[i] = CH_STOPPED;
        endcase
      end
      // RULE7: reset does not clear flags
      // RULE9: cycle event sets, set beats clear
      if (cycle_done_evt[i]) begin
        st_d.cyc_flag[i] = 1'b1;
      end else if (clr_cyc[i]) begin
        st_d.cyc_flag[i] = 1'b0;
      end
      // RULE10: script event sets, set beats clear
      if (script_done_evt[i]) begin
        st_d.scr_flag[i] = 1'b1;
      end else if (clr_scr[i]) begin
        st_d.scr_flag[i] = 1'b0;
      end
    end
    // read mux
    raw_status = {st_q.scr_flag, st_q.cyc_flag};
    st_d.rdata = READ_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        // RULE8: reserved bits read zero
        // RULE13: unmasked view
        RAW_STATUS_ADDR: st_d.rdata = {2'h0, raw_status};
        MASKED_STATUS_ADDR: st_d.rdata = {2'h0, masked_status};
        default: st_d.rdata = READ_IDLE;
      endcase
    end else begin
      st_d.rdata = st_q.rdata;
    end
  end

  // register the state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q.rst_pulse <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        st_q.ch[i] <= CH_STOPPED;
      end
      // RULE11: script flags reset zero
      st_q.scr_flag <= FLAGS_RESET;
      // RULE12: cycle flags reset zero
      st_q.cyc_flag <= FLAGS_RESET;
      st_q.rdata <= READ_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==================================================================
  // outputs
  // RULE15: masked status from masks
  // RULE14: mask one blocks the flag
  assign masked_status = {st_q.scr_flag & ~script_done_mask, st_q.cyc_flag & ~cycle_done_mask};
  assign irq_any = |masked_status;
  assign reg_rdata = st_q.rdata;
  assign channel_reset_pulse = st_q.rst_pulse;
  // RULE6: pointer rewind only, memory untouched
  assign script_ptr_rewind = st_q.rst_pulse;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      channel_running[i] = (st_q.ch[i] == CH_RUNNING);
      pattern_load[i] = (st_q.ch[i] == CH_LOADING);
    end
  end

  // ==================================================================
  // assertions
  // RULE3: no write, no pulse
  AST_PULSE_ONCE: assert property (@(posedge clock) disable iff (!nrst) // RULE3
    !(reg_wr && reg_addr == SOFT_RESET_ADDR) |=> channel_reset_pulse == '0)
    else $error("reset pulse held without write");
  // RULE5: reset halts channel
  AST_RESET_STOPS: assert property (@(posedge clock) disable iff (!nrst) // RULE5
    rst_sel[0] |=> !channel_running[0] ##1 !channel_running[0])
    else $error("channel 0 ran after reset");
  // RULE4: load then stay stopped
  AST_LOAD_THEN_STOP: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    rst_sel[2] |=> (pattern_load[2] && script_ptr_rewind[2]) ##1 !channel_running[2])
    else $error("channel 2 missed load");
  // RULE16: every selected channel
  AST_MULTI: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    (reg_wr && reg_addr == SOFT_RESET_ADDR)
      |=> {5'h00, channel_reset_pulse} == ($past(reg_wdata) & 8'h07))
    else $error("reset selection mismatch");
  // RULE7: flags survive reset
  AST_FLAGS_KEPT: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    rst_sel != '0 |=> (raw_status & $past(raw_status)) == $past(raw_status))
    else $error("reset cleared a flag");
  // RULE7: host clear works
  AST_CLEAR_WORKS: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    (reg_wr && reg_addr == IRQ_CLEAR_ADDR && reg_wdata[3] && !script_done_evt[0])
      |=> !raw_status[3])
    else $error("script flag not cleared");
  // RULE9: cycle event sets
  AST_CYC_SET: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    cycle_done_evt[2] |=> raw_status[2])
    else $error("cycle flag not set");
  // RULE9: set beats clear
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    cycle_done_evt[0] |=> raw_status[0])
    else $error("cycle flag lost");
  // RULE10: script event sets
  AST_SCR_SET: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    script_done_evt[0] |=> raw_status[3])
    else $error("script flag not set");
  // RULE8: raw read view
  AST_RAW_READ: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    (reg_rd && reg_addr == RAW_STATUS_ADDR) |=> reg_rdata == {2'h0, $past(raw_status)})
    else $error("raw read mismatch");
  // RULE8: reserved bits zero
  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    reg_rdata[7:6] == 2'h0)
    else $error("reserved read bits set");
  // RULE15: cycle mask gates
  AST_MASKED: assert property (@(posedge clock) disable iff (!nrst) // RULE15
    cycle_done_mask[1] |-> !masked_status[1])
    else $error("masked bit leaked");
  // RULE15: script mask gates
  AST_SCR_MASKED: assert property (@(posedge clock) disable iff (!nrst) // RULE15
    script_done_mask[2] |-> !masked_status[5])
    else $error("masked script bit leaked");
  // RULE14: zero mask passes
  AST_UNMASKED_PASS: assert property (@(posedge clock) disable iff (!nrst) // RULE14
    !cycle_done_mask[0] |-> masked_status[0] == raw_status[0])
    else $error("unmasked bit blocked");
  // RULE15: summary line follows
  AST_IRQ_ANY: assert property (@(posedge clock) disable iff (!nrst) // RULE15
    irq_any == (masked_status != 6'h00))
    else $error("summary line mismatch");
endmodule

/* common/pwm_reset_pkg.sv */
// Purpose: constants for the pwm timer reset and raw status block
// Assumes: byte-wide register port from the serial command interpreter
// Notes: offsets are byte addresses in the command register space
// ====================================================================
// package
package pwm_reset_pkg;
  localparam int unsigned NUM_CH = 3;                     // timer channels
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h78;         // write-only reset register
  localparam logic [7:0] RAW_STATUS_ADDR = 8'h7A;         // read-only raw status
  localparam logic [7:0] MASKED_STATUS_ADDR = 8'h7B;      // masked status
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h7C;          // interrupt clear register
  localparam int unsigned RESET_CH_LSB = 0;               // reset select bits 2:0
  localparam int unsigned CYCLE_FLAG_LSB = 0;             // cycle done flags 2:0
  localparam int unsigned SCRIPT_FLAG_LSB = 3;            // script done flags 5:3
  localparam logic [2:0] FLAGS_RESET = 3'h0;              // flag value after reset
  localparam logic [7:0] READ_IDLE = 8'h00;               // read data of unmapped address
  // channel engine states
  typedef enum logic [1:0] {
    CH_STOPPED = 2'b00,
    CH_LOADING = 2'b01,
    CH_RUNNING = 2'b10
  } ch_state_e;
endpackage

/* sim/evt_src.sv */
// Purpose: pwm engine model that raises completion events
// Assumes: events are one-cycle high pulses on the clock
// Notes: the bench calls fire to send a burst
// ====================================================
`timescale 1ns/1ps
module evt_src (
  // clock
  input wire logic clock,
  // events toward the block
  output logic [2:0] cyc,
  output logic [2:0] scr
);
  // idle with no event pending
  initial begin
    cyc = 3'h0;
    scr = 3'h0;
  end
  task automatic fire(input logic [2:0] c, input logic [2:0] s);
    @(posedge clock);
    cyc <= c;
    scr <= s;
    @(posedge clock);
    cyc <= 3'h0;
    scr <= 3'h0;
  endtask
endmodule

/* sim/testbench.sv */
// Purpose: self-checking bench for soft reset and raw status
// Assumes: inputs change on the rising edge, outputs read at the falling edge
// Notes: one task per scenario, watchdog ends a hang
// ====================================================
`timescale 1ns/1ps
module testbench;
  import pwm_reset_pkg::*;
  // stimulus and observed signals
  logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic [2:0] cyc, scr, start = 3'h0, cmask = 3'h0, smask = 3'h0;
  logic [2:0] rst_p, run, rew, load;
  logic [5:0] mstat;
  logic irq;
  int err_total = 0, checks = 0;
  // 50 ns clock
  always #25 clock = ~clock;
  evt_src env (.clock(clock), .cyc(cyc), .scr(scr));
  pwm_timer_reset_and_raw_irq dut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cycle_done_evt(cyc), .script_done_evt(scr), .engine_start(start),
    .cycle_done_mask(cmask), .script_done_mask(smask), .channel_reset_pulse(rst_p),
    .channel_running(run), .script_ptr_rewind(rew), .pattern_load(load),
    .masked_status(mstat), .irq_any(irq));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one byte write, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(negedge clock);
  endtask
  // one byte read, data settled after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rv = reg_rdata;
  endtask
  // flags after reset and events under masks
  task automatic t_flags();
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h00);
    @(posedge clock);
    cmask <= 3'h7;
    smask <= 3'h7;
    env.fire(3'h5, 3'h2);
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h15);
    check({2'b00, mstat}, 8'h00);
    check({7'h00, irq}, 8'h00);
    @(posedge clock);
    smask <= 3'h0;
    @(negedge clock);
    check({2'b00, mstat}, 8'h10);
    check({7'h00, irq}, 8'h01);
  endtask
  // start all, reset channels 0 and 2 with upper bits set
  task automatic t_reset();
    @(posedge clock);
    start <= 3'h7;
    @(posedge clock);
    start <= 3'h0;
    repeat (2) @(negedge clock);
    check({5'h00, run}, 8'h07);
    wr(SOFT_RESET_ADDR, 8'hFD);
    check({5'h00, rst_p}, 8'h05);
    check({5'h00, rew}, 8'h05);
    check({5'h00, load}, 8'h05);
    @(negedge clock);
    check({5'h00, rst_p}, 8'h00);
    check({5'h00, run}, 8'h02);
    check({5'h00, rew}, 8'h00);
    check({5'h00, load}, 8'h00);
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h15);
  endtask
  // read-only status and an unmapped place
  task automatic t_ro();
    wr(RAW_STATUS_ADDR, 8'hFF);
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h15);
    rd(8'h79);
    check(rv, READ_IDLE);
    rd(MASKED_STATUS_ADDR);
    check(rv, 8'h10);
  endtask
  // hardware reset in mid-run clears every flag
  task automatic t_hwreset();
    @(posedge clock);
    nrst <= 1'b0;
    @(negedge clock);
    check({2'b00, mstat}, 8'h00);
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h00);
  endtask
  // host clear, with an event landing on the clearing edge
  task automatic t_clear();
    env.fire(3'h7, 3'h7);
    fork
      wr(IRQ_CLEAR_ADDR, 8'h3F);
      env.fire(3'h1, 3'h0);
    join
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h01);
    wr(IRQ_CLEAR_ADDR, 8'h01);
    rd(RAW_STATUS_ADDR);
    check(rv, 8'h00);
  endtask
  // verdict
  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_flags();
    t_reset();
    t_ro();
    t_hwreset();
    t_clear();
    summarize();
  end
  // watchdog
  initial begin
    #100us;
    err_total++;
    summarize();
  end
endmodule
